// *** hw/hub_port_phy_config_regs.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Bits 3:2 set port two drive boost: none, low, medium, high.
// - Bits 1:0 set port one drive boost with the same four levels.
// - A set swap bit exchanges D+ and D- between the port's two pins.
// - Swap bit 0 upstream, bit 1 port one, bit 2 port two; rest reserved.
// - Remap register takes effect only while map enable is set.
// - Bits 7:4 map physical port two: disabled, logical 1 or 2.
// - Bits 3:0 map physical port one: disabled, logical 1 or 2.
module hub_port_phy_config_regs (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic [7:0] cfg_addr,
   input  wire logic       cfg_wr,
   input  wire logic [7:0] cfg_wdata,
   output logic      [7:0] cfg_rdata,
   input  wire logic       logical_map_enable,
   output logic      [1:0] first_port_tx_boost,
   output logic      [1:0] second_port_tx_boost,
   output logic      [1:0] phys1_logical_num,
   output logic      [1:0] phys2_logical_num,
   output logic      [1:0] reported_port_count,
   input  wire logic [2:0] core_tx_plus,
   input  wire logic [2:0] core_tx_minus,
   input  wire logic [2:0] core_tx_oe,
   output logic      [2:0] core_rx_plus,
   output logic      [2:0] core_rx_minus,
   output logic      [2:0] positive_line_pin_o,
   output logic      [2:0] positive_line_pin_oe,
   input  wire logic [2:0] positive_line_pin_i,
   output logic      [2:0] negative_line_pin_o,
   output logic      [2:0] negative_line_pin_oe,
   input  wire logic [2:0] negative_line_pin_i
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [7:0] drive_boost_q;
   logic [7:0] line_swap_bits_q;
   logic [7:0] logical_map_fields_q;
   logic [1:0] phys1_logical_num_q;
   logic [1:0] phys2_logical_num_q;
   logic [1:0] reported_port_count_q;
   logic [7:0] cfg_rdata_q;
   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   wire        hit_boost = (cfg_addr == hub_port_cfg_pkg::DRIVE_BOOST_ADDR);
   wire        hit_swap  = (cfg_addr == hub_port_cfg_pkg::PIN_SWAP_ADDR);
   wire        hit_map   = (cfg_addr == hub_port_cfg_pkg::PORT_MAP_ADDR);
   wire [7:0]  rdata_d   = hit_boost ? drive_boost_q :
                           hit_swap  ? line_swap_bits_q :
                           hit_map   ? logical_map_fields_q : 8'h00;
   wire [7:0]  boost_d   = cfg_wdata & hub_port_cfg_pkg::BOOST_MASK;
   wire [7:0]  swap_d    = cfg_wdata & hub_port_cfg_pkg::SWAP_MASK;
   // ----------------------------------------
   // Logical port mapping
   // ----------------------------------------
   wire [3:0]  map1_f  = logical_map_fields_q[hub_port_cfg_pkg::MAP1_LSB +: hub_port_cfg_pkg::MAP_W];
   wire [3:0]  map2_f  = logical_map_fields_q[hub_port_cfg_pkg::MAP2_LSB +: hub_port_cfg_pkg::MAP_W];
   wire [1:0]  map1_n  = (map1_f == hub_port_cfg_pkg::MAP_LOGICAL_1) ? hub_port_cfg_pkg::LOGICAL_1 :
                         (map1_f == hub_port_cfg_pkg::MAP_LOGICAL_2) ? hub_port_cfg_pkg::LOGICAL_2 :
                         hub_port_cfg_pkg::LOGICAL_NONE;
   wire [1:0]  map2_n  = (map2_f == hub_port_cfg_pkg::MAP_LOGICAL_1) ? hub_port_cfg_pkg::LOGICAL_1 :
                         (map2_f == hub_port_cfg_pkg::MAP_LOGICAL_2) ? hub_port_cfg_pkg::LOGICAL_2 :
                         hub_port_cfg_pkg::LOGICAL_NONE;
   wire [1:0]  phys1_d = logical_map_enable ? map1_n : hub_port_cfg_pkg::LOGICAL_1;
   wire [1:0]  phys2_d = logical_map_enable ? map2_n : hub_port_cfg_pkg::LOGICAL_2;
   wire [1:0]  count_d = logical_map_enable ?
                         ({1'b0, (map1_n != hub_port_cfg_pkg::LOGICAL_NONE)} +
                          {1'b0, (map2_n != hub_port_cfg_pkg::LOGICAL_NONE)}) :
                         hub_port_cfg_pkg::PHYS_PORT_COUNT;

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         drive_boost_q         <= hub_port_cfg_pkg::DRIVE_BOOST_RESET;
         line_swap_bits_q      <= hub_port_cfg_pkg::PIN_SWAP_RESET;
         logical_map_fields_q  <= hub_port_cfg_pkg::PORT_MAP_RESET;
         phys1_logical_num_q   <= hub_port_cfg_pkg::LOGICAL_1;
         phys2_logical_num_q   <= hub_port_cfg_pkg::LOGICAL_2;
         reported_port_count_q <= hub_port_cfg_pkg::PHYS_PORT_COUNT;
         cfg_rdata_q           <= 8'h00;
      end
      else
      begin
         if (cfg_wr && hit_boost)
            drive_boost_q <= boost_d;
         if (cfg_wr && hit_swap)
            line_swap_bits_q <= swap_d;
         if (cfg_wr && hit_map)
            logical_map_fields_q <= cfg_wdata;
         phys1_logical_num_q   <= phys1_d;
         phys2_logical_num_q   <= phys2_d;
         reported_port_count_q <= count_d;
         cfg_rdata_q           <= rdata_d;
      end
   end
   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign first_port_tx_boost  = drive_boost_q[hub_port_cfg_pkg::BOOST1_LSB +: hub_port_cfg_pkg::BOOST_W];
   assign second_port_tx_boost = drive_boost_q[hub_port_cfg_pkg::BOOST2_LSB +: hub_port_cfg_pkg::BOOST_W];
   assign phys1_logical_num    = phys1_logical_num_q;
   assign phys2_logical_num    = phys2_logical_num_q;
   assign reported_port_count  = reported_port_count_q;
   assign cfg_rdata            = cfg_rdata_q;
   // ----------------------------------------
   // Per-port line swap
   // ----------------------------------------
   genvar p;
   generate
      for (p = 0; p < hub_port_cfg_pkg::SWAP_PORTS; p++)
      begin : g_port
         line_pin_swap u_swap (
            .core_clk             (core_clk),
            .rst                  (rst),
            .swap_en              (line_swap_bits_q[p]),
            .tx_plus              (core_tx_plus[p]),
            .tx_minus             (core_tx_minus[p]),
            .tx_oe                (core_tx_oe[p]),
            .rx_plus              (core_rx_plus[p]),
            .rx_minus             (core_rx_minus[p]),
            .positive_line_pin_o  (positive_line_pin_o[p]),
            .positive_line_pin_oe (positive_line_pin_oe[p]),
            .positive_line_pin_i  (positive_line_pin_i[p]),
            .negative_line_pin_o  (negative_line_pin_o[p]),
            .negative_line_pin_oe (negative_line_pin_oe[p]),
            .negative_line_pin_i  (negative_line_pin_i[p])
         );
      end
   endgenerate
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_BOOST2_WRITE: assert property (@(posedge core_clk) disable iff (rst)
      cfg_wr && hit_boost |=> second_port_tx_boost == $past(cfg_wdata[3:2]))
      else $error("Port two boost not loaded from bits 3:2");
   AST_BOOST1_WRITE: assert property (@(posedge core_clk) disable iff (rst)
      cfg_wr && hit_boost |=> first_port_tx_boost == $past(cfg_wdata[1:0]))
      else $error("Port one boost not loaded from bits 1:0");
   AST_SWAP_RESERVED: assert property (@(posedge core_clk) disable iff (rst)
      cfg_wr && hit_swap |=> ##1 cfg_rdata[7:3] == 5'h00 || !$past(hit_swap))
      else $error("Reserved swap bits read back nonzero");
   AST_SWAP_PORT2: assert property (@(posedge core_clk) disable iff (rst)
      line_swap_bits_q[2] |=>
      positive_line_pin_o[2] == $past(core_tx_minus[2]))
      else $error("Port two swap does not route D- to positive pin");
   AST_MAP_GATED: assert property (@(posedge core_clk) disable iff (rst)
      !logical_map_enable ##1 !logical_map_enable |->
      phys1_logical_num == 2'h1 && phys2_logical_num == 2'h2)
      else $error("Mapping applied while map enable is clear");
   AST_MAP_PORT2: assert property (@(posedge core_clk) disable iff (rst)
      logical_map_enable && map2_f == 4'h0 |=> phys2_logical_num == 2'h0)
      else $error("Port two not disabled by code 0000");
   AST_MAP_PORT1: assert property (@(posedge core_clk) disable iff (rst)
      logical_map_enable && map1_f == 4'h2 |=> phys1_logical_num == 2'h2)
      else $error("Port one not mapped to logical 2");
   AST_MAP_DEFAULT: assert property (@(posedge core_clk) disable iff (rst)
      $fell(logical_map_enable) |=> phys1_logical_num == 2'h1 && phys2_logical_num == 2'h2)
      else $error("Identity mapping not restored");
   AST_PORT_COUNT: assert property (@(posedge core_clk) disable iff (rst)
      logical_map_enable && map1_f == 4'h0 && map2_f == 4'h1 |=> reported_port_count == 2'h1)
      else $error("Reported count differs from enabled ports");
   AST_BOOST_RESERVED: assert property (@(posedge core_clk) disable iff (rst)
      cfg_wr && hit_boost |=>
      drive_boost_q[7:4] == 4'h0)
      else $error("Reserved boost bits stored nonzero");
   AST_BOOST_HOLD: assert property (@(posedge core_clk) disable iff (rst)
      !(cfg_wr && hit_boost) |=>
      $stable(drive_boost_q))
      else $error("Boost register changed without a write");
   AST_SWAP_BITS: assert property (@(posedge core_clk) disable iff (rst)
      cfg_wr && hit_swap |=>
      line_swap_bits_q == {5'h00, $past(cfg_wdata[2:0])})
      else $error("Swap bits not loaded from bits 2:0");
   AST_SWAP_HOLD: assert property (@(posedge core_clk) disable iff (rst)
      !(cfg_wr && hit_swap) |=>
      $stable(line_swap_bits_q))
      else $error("Swap register changed without a write");
   AST_SWAP_PORT1: assert property (@(posedge core_clk) disable iff (rst)
      line_swap_bits_q[1] |=>
      negative_line_pin_o[1] == $past(core_tx_plus[1]))
      else $error("Port one swap does not route D+ to negative pin");
   AST_SWAP_UP_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
      !line_swap_bits_q[0] |=>
      positive_line_pin_o[0] == $past(core_tx_plus[0]))
      else $error("Upstream port not in normal pin assignment");
   AST_SWAP_SENSE: assert property (@(posedge core_clk) disable iff (rst)
      line_swap_bits_q[2] && !$past(rst, 2) |=>
      core_rx_plus[2] == $past(negative_line_pin_i[2], 3))
      else $error("Port two swap does not sense D+ on negative pin");
   AST_OE_FOLLOW: assert property (@(posedge core_clk) disable iff (rst)
      !$past(rst) |->
      negative_line_pin_oe[2] == $past(core_tx_oe[2]))
      else $error("Pin enable does not follow core enable");
   AST_MAP_WRITE: assert property (@(posedge core_clk) disable iff (rst)
      cfg_wr && hit_map |=>
      logical_map_fields_q == $past(cfg_wdata))
      else $error("Map register not loaded from write data");
   AST_MAP_PORT2_ONE: assert property (@(posedge core_clk) disable iff (rst)
      logical_map_enable && map2_f == 4'h1 |=>
      phys2_logical_num == 2'h1)
      else $error("Port two not mapped to logical 1");
   AST_MAP_PORT2_TWO: assert property (@(posedge core_clk) disable iff (rst)
      logical_map_enable && map2_f == 4'h2 |=>
      phys2_logical_num == 2'h2)
      else $error("Port two not mapped to logical 2");
   AST_MAP_PORT1_OFF: assert property (@(posedge core_clk) disable iff (rst)
      logical_map_enable && map1_f == 4'h0 |=>
      phys1_logical_num == 2'h0)
      else $error("Port one not disabled by code 0000");
   AST_MAP_PORT1_ONE: assert property (@(posedge core_clk) disable iff (rst)
      logical_map_enable && map1_f == 4'h1 |=>
      phys1_logical_num == 2'h1)
      else $error("Port one not mapped to logical 1");
   AST_COUNT_FULL: assert property (@(posedge core_clk) disable iff (rst)
      !logical_map_enable |=>
      reported_port_count == 2'h2)
      else $error("Count not two while mapping is off");
   AST_COUNT_BOTH: assert property (@(posedge core_clk) disable iff (rst)
      logical_map_enable && map1_f == 4'h1 && map2_f == 4'h2 |=>
      reported_port_count == 2'h2)
      else $error("Count not two with both ports mapped");
   AST_COUNT_NONE: assert property (@(posedge core_clk) disable iff (rst)
      logical_map_enable && map1_f == 4'h0 && map2_f == 4'h0 |=>
      reported_port_count == 2'h0)
      else $error("Count not zero with both ports disabled");
endmodule // hub_port_phy_config_regs

// *** shared/hub_port_cfg_pkg.sv ***
package hub_port_cfg_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] DRIVE_BOOST_ADDR   = 8'hF8;
   localparam logic [7:0] PIN_SWAP_ADDR      = 8'hFA;
   localparam logic [7:0] PORT_MAP_ADDR      = 8'hFB;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] DRIVE_BOOST_RESET  = 8'h00;
   localparam logic [7:0] PIN_SWAP_RESET     = 8'h00;
   localparam logic [7:0] PORT_MAP_RESET     = 8'h21;
   // ----------------------------------------
   // Field positions and widths
   // ----------------------------------------
   localparam int         BOOST1_LSB         = 0;
   localparam int         BOOST2_LSB         = 2;
   localparam int         BOOST_W            = 2;
   localparam logic [7:0] BOOST_MASK         = 8'h0F;
   localparam int         SWAP_UP_BIT        = 0;
   localparam int         SWAP_DN1_BIT       = 1;
   localparam int         SWAP_DN2_BIT       = 2;
   localparam int         SWAP_PORTS         = 3;
   localparam logic [7:0] SWAP_MASK          = 8'h07;
   localparam int         MAP1_LSB           = 0;
   localparam int         MAP2_LSB           = 4;
   localparam int         MAP_W              = 4;
   // ----------------------------------------
   // Map field codes
   // ----------------------------------------
   localparam logic [3:0] MAP_DISABLED       = 4'h0;
   localparam logic [3:0] MAP_LOGICAL_1      = 4'h1;
   localparam logic [3:0] MAP_LOGICAL_2      = 4'h2;
   localparam logic [1:0] LOGICAL_NONE       = 2'h0;
   localparam logic [1:0] LOGICAL_1          = 2'h1;
   localparam logic [1:0] LOGICAL_2          = 2'h2;
   localparam logic [1:0] PHYS_PORT_COUNT    = 2'h2;
   // ----------------------------------------
   // Drive boost levels
   // ----------------------------------------
   typedef enum logic [1:0] {
      BOOST_NONE   = 2'b00,
      BOOST_LOW    = 2'b01,
      BOOST_MEDIUM = 2'b10,
      BOOST_HIGH   = 2'b11
   } boost_level_t;
endpackage

// *** hw/line_pin_swap.sv ***
`timescale 1ns/1ps
module line_pin_swap (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic swap_en,
   input  wire logic tx_plus,
   input  wire logic tx_minus,
   input  wire logic tx_oe,
   output logic      rx_plus,
   output logic      rx_minus,
   output logic      positive_line_pin_o,
   output logic      positive_line_pin_oe,
   input  wire logic positive_line_pin_i,
   output logic      negative_line_pin_o,
   output logic      negative_line_pin_oe,
   input  wire logic negative_line_pin_i
);
   // ----------------------------------------
   // Pin input synchronisers
   // ----------------------------------------
   logic [1:0] pos_sync_q;
   logic [1:0] neg_sync_q;
   wire        pos_s = pos_sync_q[1];
   wire        neg_s = neg_sync_q[1];
   // ----------------------------------------
   // Line steering
   // ----------------------------------------
   wire        pos_d    = swap_en ? tx_minus : tx_plus;
   wire        neg_d    = swap_en ? tx_plus  : tx_minus;
   wire        rx_pl_d  = swap_en ? neg_s    : pos_s;
   wire        rx_mi_d  = swap_en ? pos_s    : neg_s;

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         pos_sync_q           <= 2'h0;
         neg_sync_q           <= 2'h0;
         positive_line_pin_o  <= 1'b0;
         negative_line_pin_o  <= 1'b0;
         positive_line_pin_oe <= 1'b0;
         negative_line_pin_oe <= 1'b0;
         rx_plus              <= 1'b0;
         rx_minus             <= 1'b0;
      end
      else
      begin
         pos_sync_q           <= {pos_sync_q[0], positive_line_pin_i};
         neg_sync_q           <= {neg_sync_q[0], negative_line_pin_i};
         positive_line_pin_o  <= pos_d;
         negative_line_pin_o  <= neg_d;
         positive_line_pin_oe <= tx_oe;
         negative_line_pin_oe <= tx_oe;
         rx_plus              <= rx_pl_d;
         rx_minus             <= rx_mi_d;
      end
   end

   AST_SWAP_DRIVE: assert property (@(posedge core_clk) disable iff (rst)
      positive_line_pin_o == ($past(swap_en) ? $past(tx_minus) : $past(tx_plus)))
      else $error("Positive line pin does not follow swap setting");
endmodule // line_pin_swap

// *** test/cfg_loader_model.sv ***
`timescale 1ns/1ps
module cfg_loader_model (
   input  wire logic       core_clk,
   output logic      [7:0] cfg_addr,
   output logic            cfg_wr,
   output logic      [7:0] cfg_wdata
);
   initial
   begin
      cfg_addr  = 8'h00;
      cfg_wr    = 1'b0;
      cfg_wdata = 8'h00;
   end
   // -------------------------
   // One byte load, strobe one clock
   // -------------------------
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      logic [7:0] val;
      val = data;
      if (addr == hub_port_cfg_pkg::PORT_MAP_ADDR)
      begin
         if (val[7:4] > 4'h2) val[7:4] = 4'h0;
         if (val[3:0] > 4'h2) val[3:0] = 4'h0;
      end
      @(negedge core_clk);
      cfg_addr  = addr;
      cfg_wdata = val;
      cfg_wr    = 1'b1;
      @(negedge core_clk);
      cfg_wr    = 1'b0;
      cfg_wdata = ~val;
   endtask
   task automatic point(input logic [7:0] addr);
      @(negedge core_clk);
      cfg_addr = addr;
   endtask
endmodule // cfg_loader_model

// *** test/hub_port_phy_config_regs_test.sv ***
`timescale 1ns/1ps
module hub_port_phy_config_regs_test;
   logic       core_clk, rst, cfg_wr, logical_map_enable;
   logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, v;
   logic [1:0] b1, b2, p1, p2, cnt;
   logic [2:0] tx_p, tx_m, tx_oe, rx_p, rx_m, pin_pi, pin_ni;
   logic [2:0] pos_o, pos_oe, neg_o, neg_oe, sw;
   logic [31:0] r;
   integer     seed, err_total, checks, cycles, i, k, en;
   hub_port_phy_config_regs u_dut (.core_clk(core_clk), .rst(rst), .cfg_addr(cfg_addr),
      .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .logical_map_enable(logical_map_enable), .first_port_tx_boost(b1),
      .second_port_tx_boost(b2), .phys1_logical_num(p1), .phys2_logical_num(p2),
      .reported_port_count(cnt), .core_tx_plus(tx_p), .core_tx_minus(tx_m),
      .core_tx_oe(tx_oe), .core_rx_plus(rx_p), .core_rx_minus(rx_m),
      .positive_line_pin_o(pos_o), .positive_line_pin_oe(pos_oe),
      .positive_line_pin_i(pin_pi), .negative_line_pin_o(neg_o),
      .negative_line_pin_oe(neg_oe), .negative_line_pin_i(pin_ni));
   cfg_loader_model u_src (.core_clk(core_clk), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
      .cfg_wdata(cfg_wdata));
   // -------------------------
   // Clock and timeout
   // -------------------------
   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      cycles = cycles + 1;
      if (cycles == 5000)
      begin
         err_total = err_total + 1;
         close_out();
      end
   end
   // -------------------------
   // Checking helpers
   // -------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks = checks + 1;
      if (got !== exp)
      begin
         err_total = err_total + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] addr);
      u_src.point(addr);
      @(negedge core_clk);
      v = cfg_rdata;
   endtask
   function automatic logic [2:0] pick(input logic [2:0] s, input logic [2:0] a,
                                       input logic [2:0] b);
      return (s & b) | (~s & a);
   endfunction
   function automatic logic [1:0] num(input integer e, input logic [3:0] c,
                                      input logic [1:0] id);
      return (e != 0) ? c[1:0] : id;
   endfunction
   task automatic close_out();
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // -------------------------
   // Main sequence
   // -------------------------
   initial
   begin
      seed = 32'h6a65;
      err_total = 0;
      checks = 0;
      cycles = 0;
      rst = 1'b1;
      logical_map_enable = 1'b0;
      {tx_p, tx_m, tx_oe, pin_pi, pin_ni} = 15'h0000;
      repeat (10) @(negedge core_clk);
      rst = 1'b0;
      rd(8'hF8);
      chk(v, 8'h00);
      rd(8'hFA);
      chk(v, 8'h00);
      rd(8'hFB);
      chk(v, 8'h21);
      rd(8'hF9);
      chk(v, 8'h00);
      chk({4'h0, p2, p1}, 8'h09);
      chk({6'h00, cnt}, 8'h02);
      $display("reset test done");
      for (i = 0; i < 16; i = i + 1)
      begin
         r = $random(seed);
         u_src.write_reg(8'hF8, {r[7:4], i[3:0]});
         @(negedge core_clk);
         chk({6'h00, b1}, {6'h00, i[1:0]});
         chk({6'h00, b2}, {6'h00, i[3:2]});
         rd(8'hF8);
         chk(v, {4'h0, i[3:0]});
      end
      u_src.write_reg(8'hF8, 8'h00);
      @(negedge core_clk);
      chk({4'h0, b2, b1}, 8'h00);
      $display("boost test done");
      for (i = 0; i < 8; i = i + 1)
      begin
         r = $random(seed);
         u_src.write_reg(8'hFA, {r[7:3], i[2:0]});
         rd(8'hFA);
         chk(v, {5'h00, i[2:0]});
         sw = i[2:0];
         for (k = 0; k < 4; k = k + 1)
         begin
            r = $random(seed);
            {tx_p, tx_m, tx_oe, pin_pi, pin_ni} = r[14:0];
            @(negedge core_clk);
            chk({2'h0, pos_o, neg_o}, {2'h0, pick(sw, tx_p, tx_m), pick(sw, tx_m, tx_p)});
            chk({2'h0, pos_oe, neg_oe}, {2'h0, tx_oe, tx_oe});
            repeat (2) @(negedge core_clk);
            chk({2'h0, rx_p, rx_m}, {2'h0, pick(sw, pin_pi, pin_ni), pick(sw, pin_ni, pin_pi)});
         end
      end
      $display("swap test done");
      for (en = 0; en < 2; en = en + 1)
      begin
         for (i = 0; i < 10; i = i + 1)
         begin
            r = $random(seed);
            v = (i == 9) ? r[7:0] : {i[3:0] / 4'h3, i[3:0] % 4'h3};
            u_src.write_reg(8'hFB, v);
            logical_map_enable = en[0];
            if (v[7:4] > 4'h2) v[7:4] = 4'h0;
            if (v[3:0] > 4'h2) v[3:0] = 4'h0;
            repeat (2) @(negedge core_clk);
            chk({6'h00, p1}, {6'h00, num(en, v[3:0], 2'h1)});
            chk({6'h00, p2}, {6'h00, num(en, v[7:4], 2'h2)});
            chk({6'h00, cnt}, (en != 0) ? (v[3:0] != 0) + (v[7:4] != 0) : 8'h02);
            r[7:0] = v;
            rd(8'hFB);
            chk(v, r[7:0]);
         end
      end
      logical_map_enable = 1'b0;
      repeat (2) @(negedge core_clk);
      chk({4'h0, p2, p1}, 8'h09);
      chk({6'h00, cnt}, 8'h02);
      $display("map test done");
      close_out();
   end
endmodule // hub_port_phy_config_regs_test
